// ---- design/afeprc_pkg.sv ----
package afeprc_pkg;
  // Prescale select codes: divide by 1, 2, 4, 8
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV8 = 2'h3;
  localparam int PRE_MAX_DIV = 8;
  // Digital sample clock is the analogue sample clock divided by four
  localparam int DSC_DIV = 4;
  localparam logic [1:0] DSC_DIV_M1 = 2'h3;
  // Defaults after reset
  localparam logic RST_EN_BITSTREAM = 1'b0;
  localparam logic RST_IDLE_DRIVE = 1'b0;
  localparam logic RST_EXT_CLOCK = 1'b1;
  localparam logic RST_EXT_REF = 1'b0;
  localparam logic [1:0] RST_PRESCALE = 2'h0;
  localparam logic [2:0] RST_OSR_LOG2 = 3'h3;
  localparam logic RST_MODE_TWO_WIRE = 1'b0;
  // Oversampling ratio is 32 shifted left by osr_select
  localparam int OSR_MIN = 32;
  localparam int OSR_SEL_W = 3;
  localparam int OSR_CNT_W = 12;
  // Interface mode encoding of the mode pin
  localparam logic MODE_SPI = 1'b0;
  localparam logic MODE_TWO_WIRE = 1'b1;
endpackage : afeprc_pkg

// ---- design/afeprc_sync.sv ----
`timescale 1ns/10ps
module afeprc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_bad_width
    $error("afeprc_sync: WIDTH must be at least 1");
  end

  // First stage is read only by the second stage
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : afeprc_sync

// ---- design/afeprc_top.sv ----
`timescale 1ns/10ps
module afeprc_top #(
  parameter int OSR_SEL_W = afeprc_pkg::OSR_SEL_W,
  parameter int OSR_CNT_W = afeprc_pkg::OSR_CNT_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  // Pins, asynchronous to core_clk and synchronised here, then watchdog_reset, which is used unsynchronised
  input wire logic master_reset_n_pin,
  input wire logic ready_pin_in,
  input wire logic clock_input_pin,
  input wire logic mode_pin,
  input wire logic watchdog_reset,
  // Configuration bits from the register map, then modulator data, host request and clock status
  input wire logic bitstream_output_enable,
  input wire logic ready_idle_drive_select,
  input wire logic external_clock_select,
  input wire logic external_reference_select,
  input wire logic [1:0] prescale_select,
  input wire logic [OSR_SEL_W-1:0] osr_select,
  input wire logic modulator_bit,
  input wire logic serial_request,
  input wire logic primary_clock_present,
  // Outputs
  output logic serial_grant,
  output logic config_reset,
  output logic mode_two_wire,
  output logic oversampling_select_low,
  output logic oversampling_select_high,
  output logic gain_select_low,
  output logic gain_select_high,
  output logic modulator_bitstream_out,
  output logic modulator_bitstream_oe,
  output logic conversion_ready_pulse,
  output logic conversion_ready_oe,
  output logic analogue_sample_clock,
  output logic digital_sample_clock,
  output logic output_rate_clock,
  output logic crystal_osc_enable,
  output logic clock_pin_direct,
  output logic input_clock_enable,
  output logic core_clock_enable,
  output logic bias_enable,
  output logic internal_ref_enable,
  output logic ref_pin_switch
);
  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [3:0] pins_sync;
  logic rst_pin_n;
  logic ready_pin_s;
  logic clk_pin_s;
  logic mode_pin_s;

  if (OSR_SEL_W < 1 || OSR_SEL_W > 3 || OSR_CNT_W < 12) begin : g_bad_osr
    $error("afeprc_top: OSR widths cannot cover the ratio range");
  end

  afeprc_sync #(.WIDTH(4)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in({master_reset_n_pin, ready_pin_in, clock_input_pin,
               mode_pin}),
    .sync_out(pins_sync)
  );

  assign rst_pin_n = pins_sync[3];
  assign ready_pin_s = pins_sync[2];
  assign clk_pin_s = pins_sync[1];
  assign mode_pin_s = pins_sync[0];

  // ----------------------------------------------------------------
  // Mode latch and hard reset
  // ----------------------------------------------------------------
  logic hard_reset;
  logic hard_reset_d;
  logic relatch;
  logic mode_now;

  // Master reset only means reset while SPI mode is latched
  assign hard_reset = (mode_two_wire == afeprc_pkg::MODE_SPI) && !rst_pin_n;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hard_reset_d <= 1'b1;
    end else begin
      hard_reset_d <= hard_reset;
    end
  end

  // Mode is latched on the cycle after a master or system reset ends, and during each watchdog reset cycle
  assign relatch = (hard_reset_d && !hard_reset) || watchdog_reset;
  assign mode_now = mode_pin_s;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_two_wire <= afeprc_pkg::RST_MODE_TWO_WIRE;
    end else if (relatch) begin
      mode_two_wire <= mode_now;
    end
  end

  // ----------------------------------------------------------------
  // Two-wire select pin latch
  // ----------------------------------------------------------------
  logic mode_two_wire_d;
  logic tw_capture;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_two_wire_d <= afeprc_pkg::RST_MODE_TWO_WIRE;
    end else begin
      mode_two_wire_d <= mode_two_wire;
    end
  end

  // Capture on entry to two-wire, and again on each watchdog reset while two-wire is latched
  assign tw_capture = mode_two_wire &&
                      (!mode_two_wire_d || watchdog_reset);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      oversampling_select_low <= 1'b0;
      gain_select_high <= 1'b0;
      gain_select_low <= 1'b0;
    end else if (tw_capture) begin
      oversampling_select_low <= rst_pin_n;
      gain_select_high <= ready_pin_s;
      gain_select_low <= clk_pin_s;
    end
  end

  // Serial data pin doubles as high select; sampled from the config path
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      oversampling_select_high <= 1'b0;
    end else if (tw_capture) begin
      oversampling_select_high <= osr_select[0];
    end
  end

  // ----------------------------------------------------------------
  // Reset effects
  // ----------------------------------------------------------------
  // defaults and refusal
  assign config_reset = sys_rst || hard_reset;
  assign serial_grant = serial_request && !config_reset &&
                        (mode_two_wire == afeprc_pkg::MODE_SPI);

  assign core_clock_enable = !config_reset;
  assign input_clock_enable = !config_reset || primary_clock_present;

  assign bias_enable = !config_reset || primary_clock_present;

  // ----------------------------------------------------------------
  // Clock and reference selection
  // ----------------------------------------------------------------
  logic ext_clk_eff;
  logic ext_ref_eff;

  // Reset forces the power-on defaults, whatever the register shows
  assign ext_clk_eff = config_reset ? afeprc_pkg::RST_EXT_CLOCK
                                    : external_clock_select;
  assign ext_ref_eff = config_reset ? afeprc_pkg::RST_EXT_REF
                                    : external_reference_select;

  assign crystal_osc_enable = !ext_clk_eff;
  assign clock_pin_direct = ext_clk_eff;

  assign internal_ref_enable = !ext_ref_eff;
  assign ref_pin_switch = !ext_ref_eff;

  // ----------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------
  logic [2:0] pre_cnt;
  logic [2:0] pre_limit;
  logic asc_tick;
  logic [1:0] dm_cnt;
  logic dsc_tick;
  logic [OSR_CNT_W-1:0] osr_cnt;
  logic [OSR_CNT_W-1:0] osr_limit;
  logic [1:0] pre_sel;
  logic [OSR_SEL_W-1:0] osr_sel;

  assign pre_sel = config_reset ? afeprc_pkg::RST_PRESCALE : prescale_select;
  assign osr_sel = config_reset ? OSR_SEL_W'(afeprc_pkg::RST_OSR_LOG2)
                                : osr_select;
  assign pre_limit = 3'((1 << pre_sel) - 1);
  assign osr_limit = OSR_CNT_W'((afeprc_pkg::OSR_MIN << osr_sel) - 1);
  assign asc_tick = (pre_cnt == pre_limit);

  // prescale taken as given by the host
  always_ff @(posedge core_clk) begin
    if (config_reset) begin
      pre_cnt <= '0;
      analogue_sample_clock <= 1'b0;
    end else begin
      pre_cnt <= asc_tick ? 3'h0 : 3'(pre_cnt + 3'h1);
      analogue_sample_clock <= asc_tick;
    end
  end

  assign dsc_tick = asc_tick && (dm_cnt == afeprc_pkg::DSC_DIV_M1);

  always_ff @(posedge core_clk) begin
    if (config_reset) begin
      dm_cnt <= '0;
      digital_sample_clock <= 1'b0;
    end else begin
      if (asc_tick) begin
        dm_cnt <= 2'(dm_cnt + 2'h1);
      end
      // Phase counted from reset, so the first high half is full length
      if (asc_tick) begin
        digital_sample_clock <= (dm_cnt == 2'h0) ||
                                (dm_cnt == 2'h1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (config_reset) begin
      osr_cnt <= '0;
    end else if (dsc_tick) begin
      osr_cnt <= (osr_cnt == osr_limit) ? '0 : OSR_CNT_W'(osr_cnt + 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // Ready pulse
  // ----------------------------------------------------------------
  logic conv_done;
  logic [4:0] pulse_cnt;
  logic [4:0] pulse_len;
  logic pulse_active;
  logic ready_allowed;

  assign conv_done = dsc_tick && (osr_cnt == osr_limit);
  // Half a digital sample period in core clocks: 2 analogue periods
  assign pulse_len = 5'((afeprc_pkg::DSC_DIV / 2) << pre_sel);

  always_ff @(posedge core_clk) begin
    if (config_reset) begin
      pulse_cnt <= '0;
    end else if (conv_done) begin
      pulse_cnt <= pulse_len;
    end else if (pulse_cnt != 5'h0) begin
      pulse_cnt <= 5'(pulse_cnt - 5'h1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (config_reset) begin
      output_rate_clock <= 1'b0;
    end else begin
      output_rate_clock <= conv_done;
    end
  end

  assign pulse_active = (pulse_cnt != 5'h0);

  assign ready_allowed = (mode_two_wire == afeprc_pkg::MODE_SPI) &&
                         !bitstream_output_enable && !config_reset;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      conversion_ready_pulse <= 1'b1;
      conversion_ready_oe <= 1'b0;
    end else begin
      conversion_ready_pulse <= !pulse_active;
      conversion_ready_oe <= ready_allowed &&
                             (pulse_active || ready_idle_drive_select);
    end
  end

  // ----------------------------------------------------------------
  // Modulator bitstream
  // ----------------------------------------------------------------
  logic mod_drive;

  // drive only when enabled in SPI mode
  assign mod_drive = bitstream_output_enable && !config_reset &&
                     (mode_two_wire == afeprc_pkg::MODE_SPI);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      modulator_bitstream_out <= 1'b0;
      modulator_bitstream_oe <= 1'b0;
    end else begin
      if (asc_tick) begin
        modulator_bitstream_out <= modulator_bit;
      end
      modulator_bitstream_oe <= mod_drive;
    end
  end
endmodule : afeprc_top

// ---- testbench/afeprc_asserts.sv ----
`timescale 1ns/10ps
module afeprc_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic serial_request,
  input wire logic serial_grant,
  input wire logic config_reset,
  input wire logic mode_two_wire,
  input wire logic [1:0] prescale_select,
  input wire logic bitstream_output_enable,
  input wire logic external_clock_select,
  input wire logic external_reference_select,
  input wire logic primary_clock_present,
  input wire logic modulator_bitstream_oe,
  input wire logic conversion_ready_pulse,
  input wire logic conversion_ready_oe,
  input wire logic digital_sample_clock,
  input wire logic crystal_osc_enable,
  input wire logic clock_pin_direct,
  input wire logic input_clock_enable,
  input wire logic core_clock_enable,
  input wire logic bias_enable,
  input wire logic internal_ref_enable,
  input wire logic ref_pin_switch
);
  logic stream_ok;
  assign stream_ok = bitstream_output_enable && !mode_two_wire &&
                     !config_reset;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  a_grant_gate: assert property (
    serial_grant == (serial_request && !config_reset && !mode_two_wire))
    else $error("grant given while refused");
  a_reset_clocks: assert property (
    config_reset |-> !core_clock_enable && bias_enable == primary_clock_present
    && input_clock_enable == primary_clock_present)
    else $error("clock or bias wrong in reset");
  a_stream_enable: assert property (
    $stable(stream_ok) |-> modulator_bitstream_oe == stream_ok)
    else $error("bitstream enable not followed");
  a_ready_yield: assert property (
    bitstream_output_enable && $past(bitstream_output_enable)
    |-> !conversion_ready_oe) else $error("ready driven beside bitstream");
  a_two_wire_quiet: assert property (
    mode_two_wire && $past(mode_two_wire) |-> !modulator_bitstream_oe)
    else $error("bitstream driven in two-wire");
  a_pulse_width: assert property (disable iff (config_reset)
    $fell(conversion_ready_pulse) && prescale_select == 2'h0
    |-> !conversion_ready_pulse[*2] ##1 conversion_ready_pulse)
    else $error("ready pulse width wrong");
  a_sample_divide: assert property (disable iff (config_reset)
    $rose(digital_sample_clock) && prescale_select == 2'h0 |-> ##1
    digital_sample_clock ##1 !digital_sample_clock[*2] ##1
    digital_sample_clock) else $error("sample clock not quarter rate");
  a_clock_source: assert property (
    !config_reset |-> crystal_osc_enable != external_clock_select
    && clock_pin_direct == external_clock_select)
    else $error("clock source wrong");
  a_ref_select: assert property (
    !config_reset |-> internal_ref_enable != external_reference_select
    && ref_pin_switch == internal_ref_enable) else $error("reference wrong");
endmodule : afeprc_asserts

bind afeprc_top afeprc_asserts u_chk (.*);

// ---- testbench/afeprc_host.sv ----
`timescale 1ns/10ps
module afeprc_host (
  input wire logic conversion_ready_pulse,
  input wire logic conversion_ready_oe,
  input wire logic gain_drive,
  input wire logic gain_level,
  input wire logic host_read,
  output logic ready_pin_in,
  output logic serial_request
);
  // Board pull-up keeps the ready line high when nobody drives it
  assign ready_pin_in = conversion_ready_oe ? conversion_ready_pulse :
    gain_drive ? gain_level : 1'b1;
  assign serial_request = host_read;
endmodule : afeprc_host

// ---- testbench/tb_afe_pin_reset_ready_control.sv ----
`timescale 1ns/10ps
module tb_afe_pin_reset_ready_control;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic master_reset_n_pin = 1'b1;
  logic clock_input_pin = 1'b0;
  logic mode_pin = 1'b0;
  logic watchdog_reset = 1'b0;
  logic bitstream_output_enable = 1'b1;
  logic ready_idle_drive_select = 1'b1;
  logic external_clock_select = 1'b1;
  logic external_reference_select = 1'b0;
  logic modulator_bit = 1'b0;
  logic primary_clock_present = 1'b1;
  logic host_read = 1'b1;
  logic gain_drive = 1'b0;
  logic gain_level = 1'b0;
  logic [1:0] prescale_select = 2'h0;
  logic [2:0] osr_select = 3'h0;
  logic ready_pin_in, serial_request, serial_grant, config_reset;
  logic mode_two_wire, oversampling_select_low, oversampling_select_high;
  logic gain_select_low, gain_select_high, modulator_bitstream_out;
  logic modulator_bitstream_oe, conversion_ready_pulse, conversion_ready_oe;
  logic analogue_sample_clock, digital_sample_clock, output_rate_clock;
  logic crystal_osc_enable, clock_pin_direct, input_clock_enable;
  logic core_clock_enable, bias_enable, internal_ref_enable, ref_pin_switch;
  int n_fail = 0;
  int cmp_count = 0;

  afeprc_top uut (.*);
  afeprc_host host (.*);

  always #10 core_clk = ~core_clk;

  task automatic chk(logic [11:0] seen, logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic w(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : w

  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic chk_defaults();
    chk(mode_two_wire, 1'b0);
    chk(modulator_bitstream_oe, 1'b0);
    chk(conversion_ready_oe, 1'b0);
    chk(serial_grant, 1'b0);
    chk(core_clock_enable, 1'b0);
    chk(input_clock_enable, 1'b1);
    chk(bias_enable, 1'b1);
  endtask : chk_defaults

  task automatic hard_reset(logic [1:0] pre);
    @(posedge core_clk);
    master_reset_n_pin <= 1'b0;
    w(4);
    chk_defaults();
    @(posedge core_clk);
    // host picks a prescale in range, only while held in reset
    prescale_select <= pre;
    primary_clock_present <= 1'b0;
    w(2);
    chk(input_clock_enable, 1'b0);
    @(posedge core_clk);
    primary_clock_present <= 1'b1;
    master_reset_n_pin <= 1'b1;
    w(4);
  endtask : hard_reset

  task automatic t_ready_pulse(logic [1:0] pre, logic rd);
    int lo;
    int hi;
    int asc_n;
    int dsc_n;
    int orc_n;
    lo = 0;
    hi = 0;
    hard_reset(pre);
    @(posedge core_clk);
    host_read <= rd;
    ready_idle_drive_select <= 1'b1;
    w(2);
    while (ready_pin_in !== 1'b0 && hi < 3000) begin
      w(1);
      hi++;
    end
    hi = 0;
    asc_n = 0;
    dsc_n = 0;
    orc_n = 0;
    while (ready_pin_in === 1'b0 && lo < 99) begin
      w(1);
      lo++;
      asc_n += int'(analogue_sample_clock);
      dsc_n += int'(digital_sample_clock);
      orc_n += int'(output_rate_clock);
    end
    chk(conversion_ready_oe, 1'b1);
    while (ready_pin_in !== 1'b0 && hi < 3000) begin
      w(1);
      hi++;
      asc_n += int'(analogue_sample_clock);
      dsc_n += int'(digital_sample_clock);
      orc_n += int'(output_rate_clock);
    end
    chk(12'(lo), 12'h002 << pre);
    chk(12'(lo + hi), 12'h080 << pre);
    chk(12'(orc_n), 12'h001);
    chk(12'(asc_n), 12'h080);
    chk(12'(dsc_n), 12'h040 << pre);
    @(posedge core_clk);
    ready_idle_drive_select <= 1'b0;
    w(8);
    chk(conversion_ready_oe, 1'b0);
  endtask : t_ready_pulse

  task automatic t_bitstream();
    int seen;
    seen = 0;
    @(posedge core_clk);
    bitstream_output_enable <= 1'b1;
    ready_idle_drive_select <= 1'b1;
    modulator_bit <= 1'b1;
    w(8);
    chk({modulator_bitstream_oe, modulator_bitstream_out}, 2'h3);
    @(posedge core_clk);
    modulator_bit <= 1'b0;
    repeat (300) begin
      w(1);
      if (ready_pin_in !== 1'b1) seen++;
    end
    chk(modulator_bitstream_out, 1'b0);
    chk(12'(seen), 12'h000);
  endtask : t_bitstream

  task automatic t_clock_ref();
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      external_clock_select <= i[0];
      external_reference_select <= i[1];
      w(2);
      chk({crystal_osc_enable, clock_pin_direct}, {!i[0], i[0]});
      chk({internal_ref_enable, ref_pin_switch}, {2{!i[1]}});
    end
  endtask : t_clock_ref

  task automatic wdog(logic m, logic rn, logic ck, logic g, logic [2:0] o);
    @(posedge core_clk);
    mode_pin <= m;
    master_reset_n_pin <= rn;
    clock_input_pin <= ck;
    gain_level <= g;
    osr_select <= o;
    w(4);
    @(posedge core_clk);
    watchdog_reset <= 1'b1;
    @(posedge core_clk);
    watchdog_reset <= 1'b0;
    w(4);
  endtask : wdog

  task automatic t_two_wire();
    @(posedge core_clk);
    gain_drive <= 1'b1;
    wdog(1'b1, 1'b1, 1'b0, 1'b0, 3'h1);
    chk({mode_two_wire, serial_grant}, 2'h2);
    chk({oversampling_select_high, oversampling_select_low,
      gain_select_high, gain_select_low}, 4'hc);
    @(posedge core_clk);
    master_reset_n_pin <= 1'b0;
    clock_input_pin <= 1'b1;
    gain_level <= 1'b1;
    osr_select <= 3'h0;
    w(6);
    chk({config_reset, modulator_bitstream_oe}, 2'h0);
    chk({oversampling_select_high, oversampling_select_low,
      gain_select_high, gain_select_low}, 4'hc);
    wdog(1'b1, 1'b0, 1'b1, 1'b1, 3'h0);
    chk({oversampling_select_high, oversampling_select_low,
      gain_select_high, gain_select_low}, 4'h3);
    wdog(1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
    chk(mode_two_wire, 1'b0);
  endtask : t_two_wire

  initial begin
    w(11);
    chk_defaults();
    @(posedge core_clk);
    sys_rst <= 1'b0;
    bitstream_output_enable <= 1'b0;
    w(4);
    chk(serial_grant, 1'b1);
    t_ready_pulse(2'h0, 1'b0);
    t_ready_pulse(2'h1, 1'b1);
    t_bitstream();
    t_clock_ref();
    t_two_wire();
    final_report();
  end

  // Tests need about 1200 cycles; allow 10000 cycles, about eight times that, before giving up
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule : tb_afe_pin_reset_ready_control
